/* include/pcc_pkg.sv */
// Package of constants and types for the pedestrian clearance countdown.
package pcc_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned SEC_CYCLES     = CLK_HZ;
  // Longest dark gap inside a flashing hand interval, in milliseconds.
  localparam int unsigned FLASH_GAP_MS   = 1500;
  localparam int unsigned FLASH_GAP_CYC  = (CLK_HZ / 1000) * FLASH_GAP_MS;
  // Supply interruption limit, in milliseconds.
  localparam int unsigned PWR_LOSS_MS    = 1500;
  localparam int unsigned PWR_LOSS_CYC   = (CLK_HZ / 1000) * PWR_LOSS_MS;
  localparam logic [6:0]  MAX_COUNT      = 7'h63;
  localparam logic [6:0]  ZERO_COUNT     = 7'h00;
  localparam logic [6:0]  BLANK_SEG      = 7'h00;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    PCC_IDLE,
    PCC_WALK,
    PCC_LEARN,
    PCC_COUNT,
    PCC_HOLD
  } pcc_state_t;

  // Controller load switch indications.
  typedef struct packed {
    logic walk;
    logic hand;
  } pcc_ind_t;

  // Two seven-segment digits, each segment driving two LED rows.
  typedef struct packed {
    logic [6:0] tens;
    logic [6:0] ones;
  } pcc_seg_t;

endpackage

/* core/pcc_seg_decode.sv */
// Binary to two-digit seven-segment decoder.
`timescale 1ns/1ns
module pcc_seg_decode (
  // Value
  input  wire logic [6:0]       value_in,
  input  wire logic             blank_in,
  // Segments
  output pcc_pkg::pcc_seg_t     seg_out
);

  function automatic logic [6:0] seg7(input logic [3:0] d);
    case (d)
      4'h0: seg7 = 7'h3f;
      4'h1: seg7 = 7'h06;
      4'h2: seg7 = 7'h5b;
      4'h3: seg7 = 7'h4f;
      4'h4: seg7 = 7'h66;
      4'h5: seg7 = 7'h6d;
      4'h6: seg7 = 7'h7d;
      4'h7: seg7 = 7'h07;
      4'h8: seg7 = 7'h7f;
      4'h9: seg7 = 7'h6f;
      default: seg7 = pcc_pkg::BLANK_SEG;
    endcase
  endfunction

  logic [6:0] lim;
  logic [3:0] tens_d;
  logic [3:0] ones_d;

  always_comb begin
    lim    = (value_in > pcc_pkg::MAX_COUNT) ? pcc_pkg::MAX_COUNT : value_in;
    tens_d = 4'(lim / 7'h0a);
    ones_d = 4'(lim % 7'h0a);
    if (blank_in) begin
      seg_out = '{tens: pcc_pkg::BLANK_SEG, ones: pcc_pkg::BLANK_SEG};
    end else begin
      seg_out = '{tens: seg7(tens_d), ones: seg7(ones_d)};
    end
  end

endmodule // pcc_seg_decode

/* core/pcc_countdown.sv */
// Pedestrian clearance countdown: learns the clearance and drives two digits.
`timescale 1ns/1ns
module pcc_countdown #(
  parameter int unsigned SEC_CYC  = pcc_pkg::SEC_CYCLES,
  parameter int unsigned GAP_CYC  = pcc_pkg::FLASH_GAP_CYC,
  parameter int unsigned LOSS_CYC = pcc_pkg::PWR_LOSS_CYC
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  // Supply monitor, high while line power is present
  input  wire logic             power_ok_in,
  // Controller indications: walk person and upraised hand drives
  input  pcc_pkg::pcc_ind_t     ind_in,
  // Display
  output pcc_pkg::pcc_seg_t     seg_out,
  output logic                  digits_on_out
);

  // ==========================================================================
  // Hand classification
  // ==========================================================================
  // The hand drive toggles while flashing. A hand that stays lit for longer
  // than the gap window is steady; a dark hand shorter than the window is
  // still part of the flashing interval.
  logic [31:0] hand_on_cnt_ff,  nxt_hand_on_cnt;
  logic [31:0] hand_off_cnt_ff, nxt_hand_off_cnt;
  logic        hand_prev_ff,    nxt_hand_prev;
  logic        flash_seen;
  logic        steady_seen;
  logic        all_dark;

  always_comb begin
    nxt_hand_prev    = ind_in.hand;
    nxt_hand_on_cnt  = ind_in.hand ? ((hand_on_cnt_ff < GAP_CYC) ? hand_on_cnt_ff + 32'h1
                                                                   : hand_on_cnt_ff)
                                   : 32'h0;
    nxt_hand_off_cnt = ind_in.hand ? 32'h0
                                   : ((hand_off_cnt_ff < GAP_CYC) ? hand_off_cnt_ff + 32'h1
                                                                  : hand_off_cnt_ff);
    // Any lit hand marks flashing until the hand proves steady.
    flash_seen  = ind_in.hand && (hand_on_cnt_ff < GAP_CYC) &&
                  (!hand_prev_ff || hand_off_cnt_ff == 32'h0 || hand_on_cnt_ff != 32'h0);
    steady_seen = ind_in.hand && (hand_on_cnt_ff >= GAP_CYC);
    all_dark    = !ind_in.hand && !ind_in.walk && (hand_off_cnt_ff >= GAP_CYC);
  end

  // ==========================================================================
  // Power-loss detector
  // ==========================================================================
  logic [31:0] loss_cnt_ff, nxt_loss_cnt;
  logic        long_loss_ff, nxt_long_loss;

  always_comb begin
    nxt_loss_cnt  = power_ok_in ? 32'h0
                                : ((loss_cnt_ff < LOSS_CYC) ? loss_cnt_ff + 32'h1 : loss_cnt_ff);
    nxt_long_loss = power_ok_in ? 1'b0 : long_loss_ff;
    if (!power_ok_in && loss_cnt_ff >= LOSS_CYC) begin
      nxt_long_loss = 1'b1;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  pcc_pkg::pcc_state_t state_ff, nxt_state;
  logic [6:0]  learned_ff,  nxt_learned;   // Stored clearance in seconds.
  logic [6:0]  measure_ff,  nxt_measure;   // Clearance being measured.
  logic [6:0]  count_ff,    nxt_count;
  logic [31:0] tick_cnt_ff, nxt_tick_cnt;
  logic        valid_ff,    nxt_valid;     // A learned value is held.
  logic        show_ff,     nxt_show;      // This cycle may display.
  logic        cut_seen_ff, nxt_cut_seen;  // One early steady hand already seen.
  logic [6:0]  cut_meas_ff, nxt_cut_meas;  // Clearance measured at that cut.
  logic        sec_tick;
  logic        blank;

  always_comb begin
    nxt_state    = state_ff;
    nxt_learned  = learned_ff;
    nxt_measure  = measure_ff;
    nxt_count    = count_ff;
    nxt_valid    = valid_ff;
    nxt_show     = show_ff;
    nxt_cut_seen = cut_seen_ff;
    nxt_cut_meas = cut_meas_ff;
    nxt_tick_cnt = (tick_cnt_ff >= SEC_CYC - 1) ? 32'h0 : tick_cnt_ff + 32'h1;
    sec_tick     = (tick_cnt_ff >= SEC_CYC - 1);
    // Power failure: dark immediately, and the next cycle relearns.
    if (!power_ok_in) begin
      nxt_state = pcc_pkg::PCC_IDLE;
      nxt_show  = 1'b0;
      if (long_loss_ff) begin
        nxt_valid = 1'b0;
      end
    end else begin
      case (state_ff)
        pcc_pkg::PCC_IDLE, pcc_pkg::PCC_WALK: begin
          if (ind_in.walk) begin
            nxt_state = pcc_pkg::PCC_WALK;
          end
          if (flash_seen && !ind_in.walk) begin
            // Preempted walk lands here early; counting still starts now.
            nxt_tick_cnt = 32'h0;
            nxt_measure  = pcc_pkg::ZERO_COUNT;
            nxt_count    = learned_ff;
            nxt_state    = (valid_ff && show_ff) ? pcc_pkg::PCC_COUNT
                                                 : pcc_pkg::PCC_LEARN;
          end
        end
        pcc_pkg::PCC_LEARN, pcc_pkg::PCC_COUNT: begin
          if (sec_tick) begin
            if (measure_ff < pcc_pkg::MAX_COUNT) begin
              nxt_measure = measure_ff + 7'h1;
            end
            if (count_ff != pcc_pkg::ZERO_COUNT) begin
              nxt_count = count_ff - 7'h1;
            end
          end
          if (ind_in.walk) begin
            // New cycle without steady hand between.
            nxt_state = pcc_pkg::PCC_WALK;
            nxt_show  = valid_ff;
          end else if (steady_seen || all_dark) begin
            nxt_state = pcc_pkg::PCC_HOLD;
            if (state_ff == pcc_pkg::PCC_LEARN) begin
              if (steady_seen) begin
                nxt_learned = measure_ff;
                nxt_valid   = 1'b1;
                nxt_show    = 1'b1;
              end
            end else if (steady_seen && count_ff > 7'h1) begin
              // Early steady hand. A single cut is preemption and keeps the stored
              // value for the next cycle; the same cut twice running is a shorter timing.
              nxt_show = 1'b0;
              if (cut_seen_ff && measure_ff == cut_meas_ff) begin
                nxt_valid    = 1'b0;
                nxt_cut_seen = 1'b0;
              end else begin
                nxt_cut_seen = 1'b1;
                nxt_cut_meas = measure_ff;
              end
            end else begin
              if (all_dark) begin
                nxt_show = 1'b0;
              end
              if (steady_seen) begin
                nxt_cut_seen = 1'b0;
              end
            end
          end
          // Flashing outlasted the stored value by more than a second: timing grew.
          if (state_ff == pcc_pkg::PCC_COUNT && !ind_in.walk &&
              measure_ff > learned_ff + 7'h1) begin
            nxt_show     = 1'b0;
            nxt_valid    = 1'b0;
            nxt_cut_seen = 1'b0;
          end
        end
        pcc_pkg::PCC_HOLD: begin
          if (ind_in.walk) begin
            nxt_state = pcc_pkg::PCC_WALK;
            if (!valid_ff) begin
              nxt_show = 1'b0;
            end else begin
              nxt_show = 1'b1;
            end
          end else if (flash_seen) begin
            nxt_state = pcc_pkg::PCC_IDLE;
          end
        end
        default: nxt_state = pcc_pkg::PCC_IDLE;
      endcase
    end
    blank = !(state_ff == pcc_pkg::PCC_COUNT) || !show_ff || !power_ok_in ||
            steady_seen || all_dark;
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state_ff        <= pcc_pkg::PCC_IDLE;
      learned_ff      <= pcc_pkg::ZERO_COUNT;
      measure_ff      <= pcc_pkg::ZERO_COUNT;
      count_ff        <= pcc_pkg::ZERO_COUNT;
      tick_cnt_ff     <= 32'h0;
      valid_ff        <= 1'b0;
      show_ff         <= 1'b0;
      cut_seen_ff     <= 1'b0;
      cut_meas_ff     <= pcc_pkg::ZERO_COUNT;
      hand_on_cnt_ff  <= 32'h0;
      hand_off_cnt_ff <= 32'h0;
      hand_prev_ff    <= 1'b0;
      loss_cnt_ff     <= 32'h0;
      long_loss_ff    <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      learned_ff      <= nxt_learned;
      measure_ff      <= nxt_measure;
      count_ff        <= nxt_count;
      tick_cnt_ff     <= nxt_tick_cnt;
      valid_ff        <= nxt_valid;
      show_ff         <= nxt_show;
      cut_seen_ff     <= nxt_cut_seen;
      cut_meas_ff     <= nxt_cut_meas;
      hand_on_cnt_ff  <= nxt_hand_on_cnt;
      hand_off_cnt_ff <= nxt_hand_off_cnt;
      hand_prev_ff    <= nxt_hand_prev;
      loss_cnt_ff     <= nxt_loss_cnt;
      long_loss_ff    <= nxt_long_loss;
    end
  end

  // ==========================================================================
  // Display
  // ==========================================================================
  pcc_pkg::pcc_seg_t seg_nxt;

  pcc_seg_decode u_dec (
    .value_in (count_ff),
    .blank_in (blank),
    .seg_out  (seg_nxt)
  );

  // Segments are plain on/off levels with no dimming path.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      seg_out       <= '0;
      digits_on_out <= 1'b0;
    end else begin
      seg_out       <= seg_nxt;
      digits_on_out <= !blank;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_power_dark: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    !power_ok_in |=> !digits_on_out) else $error("Digits lit after power loss.");

  a_learn_dark: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_ff == pcc_pkg::PCC_LEARN) |=> !digits_on_out) else $error("Lit while learning.");

  a_steady_blank: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    steady_seen |=> !digits_on_out) else $error("Lit during steady hand.");

  a_dark_blank: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    all_dark |=> !digits_on_out) else $error("Lit while both dark.");

  a_count_down: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_ff == pcc_pkg::PCC_COUNT && sec_tick && count_ff != 7'h00 && power_ok_in)
    |=> count_ff == $past(count_ff) - 7'h1) else $error("Count did not decrement.");

  a_count_start: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    ($changed(state_ff) && state_ff == pcc_pkg::PCC_COUNT) |-> count_ff == learned_ff)
    else $error("Countdown did not start from learned value.");

  a_count_range: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    count_ff <= pcc_pkg::MAX_COUNT) else $error("Count out of range.");

  a_learn_store: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_ff == pcc_pkg::PCC_LEARN && steady_seen && power_ok_in && !ind_in.walk)
    |=> valid_ff && learned_ff == $past(measure_ff)) else $error("Learned value not stored.");

  sequence s_first_cut;
    state_ff == pcc_pkg::PCC_COUNT && steady_seen && count_ff > 7'h1 && !cut_seen_ff &&
    power_ok_in && !ind_in.walk;
  endsequence

  a_preempt_keep: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    s_first_cut |=> valid_ff && learned_ff == $past(learned_ff))
    else $error("Preemption changed the learned value.");

  a_rise_relearn: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_ff == pcc_pkg::PCC_COUNT && measure_ff > learned_ff + 7'h1 && power_ok_in &&
    !ind_in.walk) |=> !show_ff && !valid_ff) else $error("Longer timing not relearned.");

endmodule // pcc_countdown

/* dv/pcc_ctrl_model.sv */
// Behavioural signal controller that drives the walk and hand indications.
`timescale 1ns/1ns
module pcc_ctrl_model (
  // Clock
  input  wire logic         clk_in,
  // Cycle request and shape
  input  wire logic         go_in,
  input  wire logic [7:0]   walk_len_in,
  input  wire logic [7:0]   flash_len_in,
  input  wire logic [7:0]   steady_len_in,
  input  wire logic         dark_in,
  // Indications
  output pcc_pkg::pcc_ind_t ind_out,
  output logic              busy_out
);
  int i;
  initial begin
    ind_out  = '0;
    busy_out = 1'b0;
    forever begin
      @(posedge clk_in);
      if (go_in) begin
        @(negedge clk_in);
        busy_out = 1'b1;
        ind_out  = 2'b10;
        repeat (walk_len_in) @(negedge clk_in);
        for (i = 0; i < flash_len_in; i++) begin
          ind_out = {1'b0, ~i[2]};
          @(negedge clk_in);
        end
        ind_out = {1'b0, ~dark_in};
        repeat (steady_len_in) @(negedge clk_in);
        busy_out = 1'b0;
      end
    end
  end
endmodule // pcc_ctrl_model

/* dv/pcc_countdown_bench.sv */
// Self-checking bench for the pedestrian clearance countdown.
`timescale 1ns/1ns
module pcc_countdown_bench;
  localparam int SEC = 20;
  localparam int GAP = 8;
  localparam int LOSS = 10;
  logic core_clk_in, resetn_in, power_ok_in, go, dark, busy, digits_on;
  logic [7:0] walk_len, flash_len, steady_len;
  logic [31:0] seed;
  pcc_pkg::pcc_ind_t ind;
  pcc_pkg::pcc_seg_t seg;
  int err_total, samples_checked, cycles, lit;
  logic [6:0] v0, v1;

  pcc_countdown #(.SEC_CYC(SEC), .GAP_CYC(GAP), .LOSS_CYC(LOSS)) u_pcc_countdown (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .power_ok_in(power_ok_in),
    .ind_in(ind), .seg_out(seg), .digits_on_out(digits_on));
  pcc_ctrl_model u_pcc_ctrl_model (
    .clk_in(core_clk_in), .go_in(go), .walk_len_in(walk_len), .flash_len_in(flash_len),
    .steady_len_in(steady_len), .dark_in(dark), .ind_out(ind), .busy_out(busy));

  initial core_clk_in = 1'b0;
  always #20 core_clk_in = ~core_clk_in;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  function automatic logic [6:0] dig(input logic [6:0] s);
    logic [6:0] tbl [10];
    tbl = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f};
    if (s === 7'h00) return 7'h00;
    for (int k = 0; k < 10; k++) if (s === tbl[k]) return k[6:0];
    return 7'h7f;
  endfunction

  function automatic logic [6:0] seg2num(input pcc_pkg::pcc_seg_t s);
    return dig(s.tens) * 7'h0a + dig(s.ones);
  endfunction

  function automatic logic [6:0] start_of(input int fl);
    return 7'((fl + GAP) / SEC);
  endfunction

  task automatic cmp_bit(input string nm, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic cmp_num(input string nm, input logic [6:0] lo, hi, s);
    samples_checked++;
    if (!(s >= lo && s <= hi) || $isunknown(s)) begin
      err_total++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, s);
    end
  endtask

  task automatic run_cycle(input logic [7:0] wl, fl, sl, input logic dk);
    int n;
    int t_on;
    lit = 0;
    n = 0;
    t_on = -1;
    v0 = '1;
    v1 = '1;
    @(negedge core_clk_in);
    walk_len = wl;
    flash_len = fl;
    steady_len = sl;
    dark = dk;
    go = 1'b1;
    @(negedge core_clk_in);
    go = 1'b0;
    @(posedge core_clk_in);
    #1;
    while (busy) begin
      if (digits_on === 1'b1) begin
        if (t_on < 0) begin
          t_on = n;
          v0 = seg2num(seg);
        end
        lit++;
      end
      if (t_on >= 0 && n == t_on + SEC) v1 = seg2num(seg);
      n++;
      @(posedge core_clk_in);
      #1;
    end
    cmp_bit("digits_on at cycle end", (sl == 8'd0) && (lit != 0), digits_on);
  endtask

  // Normal cycle with random walk and steady lengths.
  task automatic run(input logic [7:0] fl);
    run_cycle(8'd4 + rnd() % 8, fl, 8'(GAP + 4) + rnd() % 8, 1'b0);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 12000) begin
      err_total++;
      results();
    end
  end

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    {go, dark, walk_len, flash_len, steady_len} = '0;
    power_ok_in = 1'b1;
    resetn_in = 1'b0;
    seed = 32'h87ef;
    {err_total, samples_checked, cycles} = '0;
    repeat (6) @(negedge core_clk_in);
    cmp_bit("seg blank in reset", 1'b1, seg === '0);
    resetn_in = 1'b1;
    run(8'd60);
    cmp_bit("lit while learning", 1'b0, lit != 0);
    run(8'd60);
    cmp_bit("lit in flash", 1'b1, lit != 0);
    cmp_num("start count", start_of(60), start_of(60) + 1, v0);
    cmp_num("count one second on", v0 - 1, v0 - 1, v1);
    run_cycle(8'd1, 8'd60, 8'd16, 1'b0);
    cmp_num("start after short walk", start_of(60), start_of(60) + 1, v0);
    run_cycle(8'd5, 8'd60, 8'd0, 1'b0);
    cmp_bit("lit first joined cycle", 1'b1, lit != 0);
    run(8'd60);
    cmp_bit("lit second joined cycle", 1'b1, lit != 0);
    run(8'd30);
    cmp_num("count through preempt", v0 - 1, v0 - 1, v1);
    run(8'd60);
    cmp_bit("lit after preempt", 1'b1, lit != 0);
    cmp_num("start after preempt", start_of(60), start_of(60) + 1, v0);
    run(8'd60);
    run(8'd120);
    run(8'd120);
    cmp_bit("lit while relearning", 1'b0, lit != 0);
    run(8'd120);
    cmp_num("start after relearn", start_of(120), start_of(120) + 1, v0);
    run_cycle(8'd4, 8'd120, 8'd20, 1'b1);
    @(negedge core_clk_in);
    power_ok_in = 1'b0;
    repeat (LOSS + 5) @(negedge core_clk_in);
    cmp_bit("digits_on without power", 1'b0, digits_on);
    power_ok_in = 1'b1;
    run(8'd60);
    cmp_bit("lit after power loss", 1'b0, lit != 0);
    run(8'd60);
    cmp_num("start after power loss", start_of(60), start_of(60) + 1, v0);
    run(8'd30);
    run(8'd30);
    run(8'd30);
    cmp_bit("lit after shorter timing", 1'b0, lit != 0);
    results();
  end
endmodule // pcc_countdown_bench
